// file: logic/twm_pkg.sv
/*
 * Shared constants, types and arithmetic for the two-wire bus master.
 * Assumes every file of the block refers to these names as twm_pkg::name.
 */
package twm_pkg;
    // Bits in one data unit before the acknowledge slot.
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // Fixed cycles added to every clock phase.
    localparam logic [15:0] SCL_EXTRA = 16'h0003;
    // Depth and width of the transmit buffer.
    localparam int TX_DEPTH = 16;
    localparam int DATA_W = 8;
    // Positions of the flags in the interrupt enable vector.
    localparam int F_TRANSFER_COMPLETE_FLAG = 0;
    localparam int F_RX_READY_FLAG = 1;
    localparam int F_TX_READY_FLAG = 2;
    localparam int F_NACK = 3;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_START_A = 4'h1,
        S_START_B = 4'h2,
        S_LOW = 4'h3,
        S_HIGH = 4'h4,
        S_STOP_A = 4'h5,
        S_STOP_B = 4'h6,
        S_STOP_C = 4'h7,
        S_RS_LOW = 4'h8
    } twm_state_t;

    typedef enum logic [1:0] {
        K_ADDR = 2'h0,
        K_INTERNAL_ADDR_BYTES = 2'h1,
        K_TXD = 2'h2,
        K_RXD = 2'h3
    } twm_kind_t;

    // Length of one clock phase in system clock cycles.
    function automatic logic [15:0] scl_period(input logic [7:0] div, input logic [2:0] ex);
        logic [15:0] wide;
        wide = {8'h00, div} << ex;
        return wide + SCL_EXTRA;
    endfunction
endpackage

// file: logic/twm_stream_if.sv
/*
 * Valid/ready byte stream between the master and its transmit buffer.
 * Assumes one producer and one consumer on the same clock.
 */
`timescale 1ns/100ps
interface twm_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

// file: logic/twm_fifo.sv
/*
 * Transmit buffer: a small memory with a registered output word.
 * Assumes a single clock and the asynchronous active high reset.
 */
`timescale 1ns/100ps
module twm_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    twm_stream_if.snk in_s,
    twm_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("twm_fifo: DEPTH must be a power of two of at least 2.");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic full_q, full_d, ov_q, ov_d, push, pull;
    logic [W-1:0] od_q, od_d;

    // Pointer, count and output stage update; a full buffer refuses writes.
    always_comb begin
        push = in_s.valid && !full_q;
        pull = (cnt_q != '0) && (!ov_q || out_s.ready);
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pull ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pull);
        full_d = (cnt_d == (AW+1)'(DEPTH));
        ov_d = pull ? 1'b1 : (out_s.ready ? 1'b0 : ov_q);
        od_d = pull ? mem_q[rd_q] : od_q;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
            ov_q <= 1'b0;
            od_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            full_q <= full_d;
            ov_q <= ov_d;
            od_q <= od_d;
        end
    end

    // Storage words carry no reset.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_s.data;
        end
    end

    assign in_s.ready = !full_q;
    assign out_s.valid = ov_q;
    assign out_s.data = od_q;
endmodule

// file: logic/twm_timer.sv
/*
 * Phase timer: a load starts a run of exactly period cycles, and done rises in its last cycle.
 * Assumes period is at least one and a load restarts any run in progress.
 */
`timescale 1ns/100ps
module twm_timer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [15:0] period,
    output logic done
);
    logic [15:0] cnt_q, cnt_d;

    // Count down towards zero; done marks the last cycle of the run, when the count is one.
    always_comb begin
        if (load) begin
            cnt_d = period;
        end else if (cnt_q != 16'h0000) begin
            cnt_d = cnt_q - 16'h0001;
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == 16'h0001);
endmodule

// file: logic/twm_master.sv
/*
 * Two-wire bus master: START, address, internal address, data, acknowledge, STOP.
 * Assumes control inputs are synchronous to sys_clk and stay stable during a transfer.
 */
// How it works
// (R1) Each unit is eight bits, most significant first, plus one acknowledge slot.
// (R2) Every transfer opens with START and closes with STOP; byte count is unlimited.
// (R3) START: data line falls while clock line is released high.
// (R4) STOP: data line rises while clock line is released high.
// (R5) Lines are only pulled low or released; both released means idle.
// (R6) Six roles exist; this block serves master transmit and master receive.
// (R7) Software sets address, dividers, disables slave and enables master before use.
// (R8) A buffer write starts START, seven-bit address and direction zero.
// (R9) In the ninth pulse the line is released, sampled, high means not acknowledged.
// (R10) Each flag drives the interrupt output when its enable is set.
// (R11) After an acknowledge the next buffered byte is loaded; ready shows buffer room.
// (R12) With no further byte buffered, the master ends the write with STOP.
// (R13) Transfer complete is set once the STOP has been finished.
// (R14) A start command with read direction sends START, address and direction one.
// (R15) Received bytes are acknowledged except the last, which is followed by STOP.
// (R16) Receive ready sets when a byte lands and clears on a holding read.
// (R17) A single-byte read gives start and stop commands in one write.
// (R18) A multi-byte read gives stop after the next-to-last byte arrived.
// (R19) A read with internal address writes the address, repeats START, then reads.
// (R20) Up to three internal address bytes; size zero sends none.
// (R21) One interrupt request output leaves the block.
// (R22) Clock low and high phases last divider shifted by exponent plus three cycles.
// (R23) Not-acknowledged sets with transfer complete and clears on a status read.
// (R24) Transfer complete also sets when master operation is enabled.
// (R25) Apart from START and STOP, the data line changes only while clock is low.
`timescale 1ns/100ps
module twm_master (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic master_enable,
    input wire logic slave_disable,
    input wire logic master_direction_read,
    input wire logic [6:0] target_address,
    input wire logic [1:0] internal_addr_size,
    input wire logic [23:0] internal_addr_bytes,
    input wire logic [2:0] clock_exponent_divider,
    input wire logic [7:0] clock_high_divider,
    input wire logic [7:0] clock_low_divider,
    input wire logic [7:0] tx_data,
    input wire logic tx_write,
    input wire logic start_cmd,
    input wire logic stop_cmd,
    input wire logic rx_read,
    input wire logic status_read,
    input wire logic [3:0] irq_enable,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe_n,
    output logic sda_out,
    output logic sda_oe_n,
    output logic tx_ready_flag,
    output logic rx_ready_flag,
    output logic transfer_complete_flag,
    output logic nack_flag,
    output logic [7:0] rx_holding_reg,
    output logic irq,
    output logic busy
);
    twm_pkg::twm_state_t st_q, st_d;
    twm_pkg::twm_kind_t kind_q, kind_d;
    logic [7:0] sh_q, sh_d, rx_q, rx_d;
    logic [3:0] bit_q, bit_d;
    logic [1:0] iad_q, iad_d;
    logic rdphase_q, rdphase_d, rdnow_q, rdnow_d, stop_q, stop_d, npend_q, npend_d;
    logic scl_oe_n_q, scl_oe_n_d, sda_oe_n_q, sda_oe_n_d;
    logic rxr_q, rxr_d, txc_q, txc_d, nack_q, nack_d, irq_q, irq_d, men_q, busy_q, busy_d;
    logic tmr_load, tmr_done, master_on, rx_set, pop, ack_end;
    logic [15:0] lo_per, hi_per, per;

    twm_stream_if #(.W(twm_pkg::DATA_W)) tx_in ();
    twm_stream_if #(.W(twm_pkg::DATA_W)) tx_out ();

    // Buffered writes enter here; a full buffer drops ready, and a write made while it is full is lost.
    assign tx_in.valid = tx_write;
    assign tx_in.data = tx_data;
    assign tx_out.ready = pop;

    twm_fifo #(.W(twm_pkg::DATA_W), .DEPTH(twm_pkg::TX_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_s(tx_in),
        .out_s(tx_out)
    );

    twm_timer u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(tmr_load),
        .period(per),
        .done(tmr_done)
    );

    // Picks one byte of the internal address, highest first.
    function automatic logic [7:0] internal_addr_bytes_byte(input logic [23:0] bytes, input logic [1:0] idx);
        return bytes[idx*8 +: 8];
    endfunction

    // Phase lengths for the clock waveform.
    always_comb begin
        lo_per = twm_pkg::scl_period(clock_low_divider, clock_exponent_divider); // R22
        hi_per = twm_pkg::scl_period(clock_high_divider, clock_exponent_divider); // R22
        per = (st_d == twm_pkg::S_LOW || st_d == twm_pkg::S_RS_LOW || st_d == twm_pkg::S_STOP_A) ? lo_per : hi_per;
        master_on = master_enable && slave_disable; // R6
        ack_end = (st_q == twm_pkg::S_HIGH) && tmr_done && (bit_q == twm_pkg::BYTE_BITS);
    end

    // Bit engine and byte sequencing.
    always_comb begin
        st_d = st_q;
        kind_d = kind_q;
        sh_d = sh_q;
        bit_d = bit_q;
        iad_d = iad_q;
        rdphase_d = rdphase_q;
        rdnow_d = rdnow_q;
        npend_d = npend_q;
        rx_d = rx_q;
        rx_set = 1'b0;
        pop = 1'b0;
        txc_d = txc_q;
        stop_d = (st_q == twm_pkg::S_IDLE) ? (start_cmd && stop_cmd) : (stop_q || stop_cmd); // R17 R18
        case (st_q)
            twm_pkg::S_IDLE: begin
                if (master_on && start_cmd && master_direction_read) begin
                    st_d = twm_pkg::S_START_A; // R14
                    rdphase_d = 1'b1;
                    rdnow_d = (internal_addr_size == 2'h0); // R19
                    sh_d = {target_address, internal_addr_size == 2'h0};
                end else if (master_on && tx_out.valid) begin
                    st_d = twm_pkg::S_START_A; // R8
                    rdphase_d = 1'b0;
                    rdnow_d = 1'b0;
                    sh_d = {target_address, 1'b0};
                end
                if (st_d == twm_pkg::S_START_A) begin
                    kind_d = twm_pkg::K_ADDR;
                    iad_d = internal_addr_size; // R20
                    txc_d = 1'b0;
                    npend_d = 1'b0;
                end
            end
            twm_pkg::S_START_A: begin
                if (tmr_done) begin
                    st_d = twm_pkg::S_START_B; // R2
                end
            end
            twm_pkg::S_START_B: begin
                if (tmr_done) begin
                    st_d = twm_pkg::S_LOW;
                    bit_d = 4'h0;
                end
            end
            twm_pkg::S_LOW: begin
                if (tmr_done) begin
                    st_d = twm_pkg::S_HIGH;
                end
            end
            twm_pkg::S_HIGH: begin
                if (tmr_done && bit_q != twm_pkg::BYTE_BITS) begin
                    sh_d = {sh_q[6:0], sda_in}; // R1
                    bit_d = bit_q + 4'h1;
                    st_d = twm_pkg::S_LOW;
                end else if (ack_end) begin
                    st_d = twm_pkg::S_LOW;
                    bit_d = 4'h0;
                    if (kind_q != twm_pkg::K_RXD && sda_in) begin
                        npend_d = 1'b1; // R9
                        st_d = twm_pkg::S_STOP_A;
                    end else if (kind_q == twm_pkg::K_RXD) begin
                        rx_d = sh_q;
                        rx_set = 1'b1;
                        if (stop_q) begin
                            st_d = twm_pkg::S_STOP_A; // R15
                        end
                    end else if (kind_q == twm_pkg::K_ADDR && rdnow_q) begin
                        kind_d = twm_pkg::K_RXD;
                    end else if (iad_q != 2'h0 && (kind_q == twm_pkg::K_ADDR || iad_q != 2'h1)) begin
                        kind_d = twm_pkg::K_INTERNAL_ADDR_BYTES; // R20
                        iad_d = (kind_q == twm_pkg::K_ADDR) ? iad_q : iad_q - 2'h1;
                        sh_d = internal_addr_bytes_byte(internal_addr_bytes, iad_d - 2'h1);
                    end else if (rdphase_q) begin
                        st_d = twm_pkg::S_RS_LOW; // R19
                        rdnow_d = 1'b1;
                        kind_d = twm_pkg::K_ADDR;
                        sh_d = {target_address, 1'b1};
                    end else if (tx_out.valid) begin
                        pop = 1'b1; // R11
                        kind_d = twm_pkg::K_TXD;
                        sh_d = tx_out.data;
                    end else begin
                        st_d = twm_pkg::S_STOP_A; // R12
                    end
                end
            end
            twm_pkg::S_RS_LOW: begin
                if (tmr_done) begin
                    st_d = twm_pkg::S_START_A;
                end
            end
            twm_pkg::S_STOP_A: begin
                if (tmr_done) begin
                    st_d = twm_pkg::S_STOP_B;
                end
            end
            twm_pkg::S_STOP_B: begin
                if (tmr_done) begin
                    st_d = twm_pkg::S_STOP_C;
                end
            end
            twm_pkg::S_STOP_C: begin
                if (tmr_done) begin
                    st_d = twm_pkg::S_IDLE;
                    txc_d = 1'b1; // R13
                    stop_d = 1'b0;
                end
            end
            default: begin
                st_d = twm_pkg::S_IDLE;
            end
        endcase
        if (master_enable && !men_q) begin
            txc_d = 1'b1; // R24
        end
        // A stretched clock restarts the high phase until the line is really high.
        tmr_load = (st_d != st_q) || (st_q == twm_pkg::S_HIGH && st_d == twm_pkg::S_HIGH && !scl_in);
        busy_d = (st_d != twm_pkg::S_IDLE);
    end

    // Line drive: clock follows the next state, data follows the present one,
    // so data moves one cycle after the clock has fallen.
    always_comb begin
        scl_oe_n_d = !(st_d == twm_pkg::S_LOW || st_d == twm_pkg::S_RS_LOW || st_d == twm_pkg::S_STOP_A); // R5
        case (st_q)
            twm_pkg::S_LOW: begin
                if (bit_q != twm_pkg::BYTE_BITS) begin
                    sda_oe_n_d = (kind_q == twm_pkg::K_RXD) ? 1'b1 : sh_q[7]; // R1 R25
                end else begin
                    sda_oe_n_d = (kind_q == twm_pkg::K_RXD) ? stop_q : 1'b1; // R9 R15
                end
            end
            twm_pkg::S_START_B: sda_oe_n_d = 1'b0; // R3
            twm_pkg::S_STOP_A: sda_oe_n_d = 1'b0; // R25
            twm_pkg::S_STOP_B: sda_oe_n_d = 1'b0;
            twm_pkg::S_STOP_C: sda_oe_n_d = 1'b1; // R4
            twm_pkg::S_HIGH: sda_oe_n_d = sda_oe_n_q;
            default: sda_oe_n_d = 1'b1;
        endcase
    end

    // Status flags; a set in the same cycle as a clear wins.
    always_comb begin
        rxr_d = rx_set || (rxr_q && !rx_read); // R16
        nack_d = (txc_d && !txc_q && npend_q) || (nack_q && !status_read); // R23
        irq_d = |({nack_q, tx_in.ready, rxr_q, txc_q} & irq_enable); // R10 R21
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= twm_pkg::S_IDLE;
            kind_q <= twm_pkg::K_ADDR;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            iad_q <= 2'h0;
            rdphase_q <= 1'b0;
            rdnow_q <= 1'b0;
            stop_q <= 1'b0;
            npend_q <= 1'b0;
            rx_q <= 8'h00;
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
            rxr_q <= 1'b0;
            txc_q <= 1'b0;
            nack_q <= 1'b0;
            irq_q <= 1'b0;
            men_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            kind_q <= kind_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            iad_q <= iad_d;
            rdphase_q <= rdphase_d;
            rdnow_q <= rdnow_d;
            stop_q <= stop_d;
            npend_q <= npend_d;
            rx_q <= rx_d;
            scl_oe_n_q <= scl_oe_n_d;
            sda_oe_n_q <= sda_oe_n_d;
            rxr_q <= rxr_d;
            txc_q <= txc_d;
            nack_q <= nack_d;
            irq_q <= irq_d;
            men_q <= master_enable;
            busy_q <= busy_d;
        end
    end

    // Output levels of the open-drain pins are always low.
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = scl_oe_n_q;
    assign sda_oe_n = sda_oe_n_q;
    assign tx_ready_flag = tx_in.ready;
    assign rx_ready_flag = rxr_q;
    assign transfer_complete_flag = txc_q;
    assign nack_flag = nack_q;
    assign rx_holding_reg = rx_q;
    assign irq = irq_q;
    assign busy = busy_q;

    // Helper: length of the current clock-low run.
    logic [15:0] low_run_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            low_run_q <= 16'h0000;
        end else begin
            low_run_q <= scl_oe_n_q ? 16'h0000 : low_run_q + 16'h0001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_ack_end;
        ack_end;
    endsequence
    sequence s_stop_end;
        st_q == twm_pkg::S_STOP_C && tmr_done;
    endsequence

    property p_start_cond;
        $fell(sda_oe_n_q) && st_q == twm_pkg::S_START_B |-> scl_oe_n_q && $past(scl_oe_n_q);
    endproperty
    a_start_cond: assert property (p_start_cond) else $error("START without clock high."); // R3
    property p_stop_cond;
        $rose(sda_oe_n_q) && st_q == twm_pkg::S_STOP_C |-> scl_oe_n_q && $past(scl_oe_n_q);
    endproperty
    a_stop_cond: assert property (p_stop_cond) else $error("STOP without clock high."); // R4
    property p_data_stable;
        $changed(sda_oe_n_q) && !(st_q inside {twm_pkg::S_START_B, twm_pkg::S_STOP_C}) |-> !scl_oe_n_q;
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("Data moved with clock high."); // R25
    property p_drive_low;
        st_q == twm_pkg::S_IDLE |-> scl_oe_n_q && sda_oe_n_q && !scl_out && !sda_out;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("Bus not released while idle."); // R5
    property p_low_time;
        $rose(scl_oe_n_q) && st_q == twm_pkg::S_HIGH |-> low_run_q == lo_per;
    endproperty
    a_low_time: assert property (p_low_time) else $error("Clock low time wrong."); // R22
    property p_nack_stop;
        s_ack_end and (kind_q != twm_pkg::K_RXD && sda_in) |=> st_q == twm_pkg::S_STOP_A && npend_q;
    endproperty
    a_nack_stop: assert property (p_nack_stop) else $error("Missing STOP after NACK."); // R9
    // The STOP length depends on the dividers, so the flag is checked at the STOP's end instead.
    property p_nack_flag;
        s_stop_end and npend_q |=> nack_flag && transfer_complete_flag;
    endproperty
    a_nack_flag: assert property (p_nack_flag) else $error("NACK flag missing after STOP."); // R23
    property p_empty_stop;
        s_ack_end and (kind_q == twm_pkg::K_TXD && !sda_in && !tx_out.valid) |=> st_q == twm_pkg::S_STOP_A;
    endproperty
    a_empty_stop: assert property (p_empty_stop) else $error("No STOP on empty buffer."); // R12
    property p_complete;
        s_stop_end |=> transfer_complete_flag && st_q == twm_pkg::S_IDLE;
    endproperty
    a_complete: assert property (p_complete) else $error("Complete flag not set after STOP."); // R13
    property p_nack_with_comp;
        $rose(nack_flag) |-> $rose(transfer_complete_flag);
    endproperty
    a_nack_with_comp: assert property (p_nack_with_comp) else $error("NACK apart from complete."); // R23
    property p_rx_land;
        rx_set |=> rx_ready_flag && rx_holding_reg == $past(sh_q);
    endproperty
    a_rx_land: assert property (p_rx_land) else $error("Received byte not flagged."); // R16
endmodule

// file: test/twm_slave_model.sv
/* Slave model on the resolved bus lines: acknowledges, records bytes and serves read data.
   Assumes pull-ups on both lines, so a released line reads high. */
`timescale 1ns/100ps
module twm_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic nack_en,
    input wire logic [7:0] rd_byte,
    output logic sda_pull = 1'b0
);
    logic [7:0] sh = 8'h00;
    logic rd = 1'b0, first = 1'b0;
    int bitn = 0, starts = 0, stops = 0;
    logic [7:0] got[$];
    // A falling data line while the clock is high opens a frame.
    always @(negedge sda) if (scl) begin
        bitn = 0;
        first = 1'b1;
        rd = 1'b0;
        starts++;
    end
    always @(posedge sda) if (scl) stops++;
    // Bits are taken on the rising clock; a released ack slot ends our reply.
    always @(posedge scl) begin
        if (bitn < 8) sh = {sh[6:0], sda};
        else if (rd && sda) rd = 1'b0;
        bitn++;
    end
    // The line is only pulled low or let go, and only while the clock is low.
    always @(negedge scl) begin
        if (bitn == 8) begin
            got.push_back(sh);
            if (first) rd = sh[0];
            sda_pull = (rd && !first) ? 1'b0 : !nack_en;
            first = 1'b0;
        end else if (bitn == 9) begin
            bitn = 0;
            sda_pull = rd & ~rd_byte[7];
        end else if (rd && bitn > 0) sda_pull = ~rd_byte[7 - bitn];
    end
endmodule

// file: test/two_wire_bus_master_bench.sv
/* Bench for the bus master: random transfers against the slave model.
   Assumes the design on a 100 ns clock and pulled-up bus lines. */
`timescale 1ns/100ps
module two_wire_bus_master_bench;
    logic sys_clk = 1'b0, rst = 1'b1, master_enable = 1'b0, slave_disable = 1'b1;
    logic master_direction_read = 1'b0, tx_write = 1'b0, start_cmd = 1'b0, stop_cmd = 1'b0;
    logic rx_read = 1'b0, status_read = 1'b0, nack_en = 1'b0;
    logic [6:0] target_address = 7'h00;
    logic [1:0] internal_addr_size = 2'h0;
    logic [23:0] internal_addr_bytes = 24'h000000;
    logic [2:0] clock_exponent_divider = 3'h1;
    logic [7:0] clock_high_divider = 8'h02, clock_low_divider = 8'h03, tx_data = 8'h00, rd_byte = 8'h00;
    logic [3:0] irq_enable = 4'h0;
    logic scl_in, sda_in, scl_out, scl_oe_n, sda_out, sda_oe_n, sda_pull, irq, busy, nack_flag;
    logic tx_ready_flag, rx_ready_flag, transfer_complete_flag;
    logic [7:0] rx_holding_reg;
    logic [7:0] eq[$];
    int seed = 57183, n_fail = 0, cmp_count = 0, lo_cnt = 0, last_lo = 0;
    // Wired-AND of all parties over the pull-ups.
    assign scl_in = scl_oe_n;
    assign sda_in = sda_oe_n & ~sda_pull;
    twm_master uut (.sys_clk, .rst, .master_enable, .slave_disable, .master_direction_read, .target_address,
        .internal_addr_size, .internal_addr_bytes, .clock_exponent_divider, .clock_high_divider,
        .clock_low_divider, .tx_data, .tx_write, .start_cmd, .stop_cmd, .rx_read, .status_read, .irq_enable,
        .scl_in, .sda_in, .scl_out, .scl_oe_n, .sda_out, .sda_oe_n, .tx_ready_flag, .rx_ready_flag,
        .transfer_complete_flag, .nack_flag, .rx_holding_reg, .irq, .busy);
    twm_slave_model m (.scl(scl_in), .sda(sda_in), .nack_en(nack_en), .rd_byte(rd_byte), .sda_pull(sda_pull));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // Measures the latest clock low phase in cycles.
    always @(posedge sys_clk) begin
        if (scl_in === 1'b0) lo_cnt <= lo_cnt + 1;
        else if (lo_cnt != 0) begin
            last_lo <= lo_cnt;
            lo_cnt <= 0;
        end
    end
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        cmp_count++;
        if (a !== e) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    task automatic finish_test();
        if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Runs one transfer; single-byte reads issue start and stop together.
    task automatic xfer(input logic [1:0] isz, input logic rd, input logic nk, input int n);
        logic [7:0] b;
        logic ok;
        int k;
        m.got.delete();
        m.starts = 0;
        m.stops = 0;
        eq.delete();
        b = 8'($random(seed));
        target_address <= b[6:0];
        clock_low_divider <= {5'h00, b[5:3]} + 8'h01;
        internal_addr_bytes <= 24'($random(seed));
        rd_byte <= 8'($random(seed));
        irq_enable <= 4'($random(seed));
        internal_addr_size <= isz;
        master_direction_read <= rd;
        nack_en <= nk;
        @(posedge sys_clk);
        ok = rd && !nk;
        eq.push_back({target_address, rd && isz == 2'h0});
        for (int j = 3; j > 0; j--) if (j <= isz) eq.push_back(internal_addr_bytes[8*j-8 +: 8]);
        if (rd) begin
            if (isz != 2'h0) eq.push_back({target_address, 1'b1});
            if (ok) repeat ((n > 1) ? n : 1) eq.push_back(rd_byte);
            start_cmd <= 1'b1;
            stop_cmd <= (n < 2);
            @(posedge sys_clk);
            start_cmd <= 1'b0;
            stop_cmd <= 1'b0;
            for (int i = 1; ok && i < n; i++) begin
                do @(posedge sys_clk); while (rx_ready_flag !== 1'b1);
                rx_read <= 1'b1;
                stop_cmd <= (i == n - 1);
                @(posedge sys_clk);
                rx_read <= 1'b0;
                stop_cmd <= 1'b0;
            end
        end else for (int i = 0; i <= n; i++) begin
            if (tx_write === 1'b1 && tx_ready_flag === 1'b1) eq.push_back(tx_data);
            tx_data <= 8'($random(seed));
            tx_write <= i < n;
            @(posedge sys_clk);
        end
        for (k = 0; k < 30000 && (k < 4 || busy !== 1'b0); k++) @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        chk(m.got.size(), eq.size());
        foreach (eq[i]) chk(m.got[i], eq[i]);
        chk(m.starts, (rd && isz != 2'h0) ? 2 : 1);
        chk(m.stops, 1);
        chk(transfer_complete_flag, 1'b1);
        chk({scl_out, sda_out, busy}, 3'h0);
        chk(nack_flag, nk);
        chk(last_lo, (int'(clock_low_divider) << clock_exponent_divider) + 3);
        chk(irq, irq_enable[0] | irq_enable[2] | (irq_enable[1] & ok) | (irq_enable[3] & nk));
        chk(rx_ready_flag, ok);
        if (ok) chk(rx_holding_reg, rd_byte);
        rx_read <= 1'b1;
        status_read <= 1'b1;
        @(posedge sys_clk);
        rx_read <= 1'b0;
        status_read <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(rx_ready_flag, 1'b0);
        chk(nack_flag, 1'b0);
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        master_enable <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(transfer_complete_flag, 1'b1);
        xfer(2'h0, 1'b0, 1'b0, 1);
        xfer(2'h2, 1'b0, 1'b0, 3);
        xfer(2'h3, 1'b0, 1'b0, 20);
        xfer(2'h0, 1'b1, 1'b0, 0);
        xfer(2'h1, 1'b1, 1'b0, 0);
        xfer(2'h0, 1'b1, 1'b1, 0);
        xfer(2'h2, 1'b1, 1'b0, 3);
        // With slave operation left on, a buffered byte must not start a transfer.
        slave_disable <= 1'b0;
        tx_write <= 1'b1;
        @(posedge sys_clk);
        tx_write <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk(busy, 1'b0);
        finish_test();
    end
    // Cuts a hang short well after the expected run length.
    initial begin
        #4000000;
        n_fail++;
        finish_test();
    end
endmodule
